// ### hw/counter_pkg.sv
/*
 Shared constants for the 4-bit synchronous counter block:
 register offsets, field positions, reset values and state codes.
 Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package counter_pkg;

	// ==========================================================
	// counter geometry
	localparam int COUNT_W = 4;               // width of the count state
	localparam logic [3:0] COUNT_ZERO = 4'h0; // cleared state
	localparam logic [3:0] BCD_LAST = 4'h9;   // final decade state
	localparam logic [3:0] BIN_LAST = 4'hF;   // final binary state
	localparam logic [3:0] COUNT_STEP = 4'h1; // one count

	// ==========================================================
	// register bus
	localparam int AXI_ADDR_W = 8;                  // byte address width
	localparam int AXI_DATA_W = 32;                 // data width
	localparam logic [7:0] WORD_MASK = 8'hFC;       // drops byte lane bits
	localparam logic [7:0] CTRL_OFF = 8'h00;        // control register
	localparam logic [7:0] STATUS_OFF = 8'h04;      // live state
	localparam logic [7:0] WRAP_OFF = 8'h08;        // terminal events
	localparam logic [1:0] RESP_OKAY = 2'h0;        // normal answer
	localparam logic [1:0] RESP_SLVERR = 2'h2;      // unmapped offset

	// ==========================================================
	// field positions and reset values
	localparam int CTRL_DECADE_BIT = 0; // 1 = decade, 0 = binary
	localparam int CTRL_GATE_BIT = 1;   // gates the parallel enable
	localparam int CTRL_CLEAR_BIT = 2;  // holds the count at zero
	localparam int STAT_TERM_BIT = 4;   // terminal flag copy
	localparam int STAT_DEC_BIT = 5;    // variant copy
	localparam logic CTRL_DECADE_RST = 1'b1;
	localparam logic CTRL_GATE_RST = 1'b1;
	localparam logic CTRL_CLEAR_RST = 1'b0;

	// ==========================================================
	// types
	typedef enum logic {
		VAR_BINARY = 1'b0,
		VAR_DECADE = 1'b1
	} variant_t;

	typedef enum logic [1:0] {
		WR_IDLE = 2'h1,
		WR_RESP = 2'h2
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'h1,
		RD_DATA = 2'h2
	} rd_state_t;

endpackage

// ### hw/count_stage.sv
/*
 One counting stage: 4-bit state, preset, two enables, async clear,
 terminal flag. Assumes its control inputs come from logic on clk.
*/
`timescale 1ns/1ps

module count_stage (
	input  wire logic                              clk,
	input  wire logic                              rst,
	input  wire logic                              masterClearN,
	input  wire logic                              syncClear,
	input  wire logic                              clockRise,
	input  wire logic                              parallelLoadN,
	input  wire logic                              countEnableParallel,
	input  wire logic                              countEnableTrickle,
	input  wire counter_pkg::variant_t             variant,
	input  wire logic [counter_pkg::COUNT_W-1:0]   presetInputs,
	output logic      [counter_pkg::COUNT_W-1:0]   countOutputs,
	output logic                                   terminalFlag
);
	import counter_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		logic [COUNT_W-1:0] count; // the count itself
	} stage_t;

	localparam stage_t STAGE_RST = '{count: COUNT_ZERO};

	stage_t stage_r;    // registered state
	stage_t stage_nxt;  // next state
	logic   clearAct;   // async clear, from reset or pin
	logic   countEn;    // combined enable
	logic   atLast;     // final-state decode
	logic [COUNT_W-1:0] stepped; // count plus one

	assign clearAct = rst | ~masterClearN;

	assign countEn = countEnableParallel & countEnableTrickle;

	assign atLast = (variant == VAR_DECADE) ? (stage_r.count == BCD_LAST)
		: (stage_r.count == BIN_LAST);
	assign terminalFlag = countEnableTrickle & atLast;

	assign stepped = stage_r.count + COUNT_STEP;

	// ==========================================================
	// next state: clear, then preset, then count, else hold
	always_comb begin
		stage_nxt = stage_r;
		if (syncClear) begin
			stage_nxt.count = COUNT_ZERO;
		end else if (clockRise) begin
			if (!parallelLoadN) begin
				stage_nxt.count = presetInputs;
			end else if (countEn) begin
				if (variant == VAR_DECADE && stage_r.count == BCD_LAST) begin
					stage_nxt.count = COUNT_ZERO;
				end else begin
					// states above nine climb to 15 then wrap to zero
					stage_nxt.count = stepped;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge clearAct) begin
		if (clearAct) begin
			stage_r <= STAGE_RST;
		end else begin
			stage_r <= stage_nxt;
		end
	end

	assign countOutputs = stage_r.count;

endmodule // count_stage

// ### hw/sync_four_bit_counter.sv
/*
 Top of the 4-bit synchronous counter with an AXI4-Lite slave for
 control and status. Assumes the counter controls come from logic on
 clk (cascaded stages share the clock), and master_clear_n may be
 asynchronous.
*/
// What this block does
// - 4-bit state changes only on clock edges or async clear
// - counts on rising edge, never falling
// - combined enable is parallel AND trickle
// - load high and enable: count, else hold
// - load low presets from inputs synchronously
// - binary variant counts straight binary
// - decade variant counts zero to nine
// - async clear forces zero, overrides all
// - terminal flag: trickle AND final state
// - terminal flag feeds next stage enables
`timescale 1ns/1ps

module sync_four_bit_counter #(
	parameter int WRAP_W = 16 // width of the terminal event counter
) (
	input  wire logic                                 clk,
	input  wire logic                                 rst,
	// write address channel
	input  wire logic [counter_pkg::AXI_ADDR_W-1:0]   awaddr,
	input  wire logic                                 awvalid,
	output logic                                      awready,
	// write data channel
	input  wire logic [counter_pkg::AXI_DATA_W-1:0]   wdata,
	input  wire logic [3:0]                           wstrb,
	input  wire logic                                 wvalid,
	output logic                                      wready,
	// write response channel
	output logic      [1:0]                           bresp,
	output logic                                      bvalid,
	input  wire logic                                 bready,
	// read address channel
	input  wire logic [counter_pkg::AXI_ADDR_W-1:0]   araddr,
	input  wire logic                                 arvalid,
	output logic                                      arready,
	// read data channel
	output logic      [counter_pkg::AXI_DATA_W-1:0]   rdata,
	output logic      [1:0]                           rresp,
	output logic                                      rvalid,
	input  wire logic                                 rready,
	// counter pins
	input  wire logic                                 masterClearN,
	input  wire logic                                 clockRise,
	input  wire logic                                 parallelLoadN,
	input  wire logic                                 countEnableParallel,
	input  wire logic                                 countEnableTrickle,
	input  wire logic [counter_pkg::COUNT_W-1:0]      presetInputs,
	output logic      [counter_pkg::COUNT_W-1:0]      countOutputs,
	output logic                                      terminalFlag
);
	import counter_pkg::*;

	// ==========================================================
	// elaboration checks
	// the event counter must fit in one bus word
	if (WRAP_W < 1 || WRAP_W > AXI_DATA_W) begin : gWrapCheck
		$error("WRAP_W must lie between 1 and the bus width");
	end

	// ==========================================================
	// state of this module
	typedef struct packed {
		wr_state_t              wrState; // write channel state
		logic                   awHeld;  // address taken, not used
		logic [AXI_ADDR_W-1:0]  awAddr;  // held write address
		logic                   wHeld;   // data taken, not used
		logic [AXI_DATA_W-1:0]  wData;   // held write data
		logic [3:0]             wStrb;   // held byte enables
		logic [1:0]             bResp;   // write answer
		rd_state_t              rdState; // read channel state
		logic [AXI_DATA_W-1:0]  rData;   // read answer data
		logic [1:0]             rResp;   // read answer code
		logic                   decade;  // variant select
		logic                   gate;    // parallel enable gate
		logic                   swClear; // software hold at zero
		logic [WRAP_W-1:0]      wrapCount; // terminal carries
	} regs_t;

	localparam regs_t REGS_RST = '{
		wrState: WR_IDLE,
		rdState: RD_IDLE,
		decade:  CTRL_DECADE_RST,
		gate:    CTRL_GATE_RST,
		swClear: CTRL_CLEAR_RST,
		default: '0
	};

	regs_t    regs_r;    // registered state
	regs_t    regs_nxt;  // next state
	variant_t variant;   // decoded variant for the stage
	logic     gatedCep;  // parallel enable after software gate
	logic     carryOut;  // stage leaves its final state this edge
	logic     awFire;    // write address handshake
	logic     wFire;     // write data handshake
	logic     arFire;    // read address handshake

	// ==========================================================
	// handshake outputs, combinational from state
	// a second address may be taken while the answer waits;
	// the master keeps one write in flight so this stays unused
	assign awready = ~regs_r.awHeld;
	assign wready  = ~regs_r.wHeld;
	assign bvalid  = (regs_r.wrState == WR_RESP);
	assign bresp   = regs_r.bResp;
	assign arready = (regs_r.rdState == RD_IDLE);
	assign rvalid  = (regs_r.rdState == RD_DATA);
	assign rdata   = regs_r.rData;
	assign rresp   = regs_r.rResp;

	assign awFire = awvalid & awready;
	assign wFire  = wvalid & wready;
	assign arFire = arvalid & arready;

	// ==========================================================
	// steering from software into the stage
	assign variant  = regs_r.decade ? VAR_DECADE : VAR_BINARY;

	assign gatedCep = countEnableParallel & regs_r.gate;

	// one carry per wrap: an enabled count edge at the final state;
	// the preset and both clears suppress it
	assign carryOut = clockRise & parallelLoadN & gatedCep
		& terminalFlag & ~regs_r.swClear & masterClearN;

	// ==========================================================
	// the counting stage
	// flag drives next stage
	// terminalFlag is combinational so a chained stage sees it
	// in the same cycle and all stages count on one edge
	count_stage uStage (
		.clk                 (clk),
		.rst                 (rst),
		.masterClearN        (masterClearN),
		.syncClear           (regs_r.swClear),
		.clockRise           (clockRise),
		.parallelLoadN       (parallelLoadN),
		.countEnableParallel (gatedCep),
		.countEnableTrickle  (countEnableTrickle),
		.variant             (variant),
		.presetInputs        (presetInputs),
		.countOutputs        (countOutputs),
		.terminalFlag        (terminalFlag)
	);

	// ==========================================================
	// next state for the bus slave and the registers
	always_comb begin
		logic [AXI_DATA_W-1:0] word;  // read mux result
		logic [AXI_ADDR_W-1:0] rdOff; // aligned read offset
		logic [AXI_ADDR_W-1:0] wrOff; // aligned write offset
		logic                  clrWrap; // software clears events
		word     = '0;
		rdOff    = araddr & WORD_MASK;
		wrOff    = regs_r.awAddr & WORD_MASK;
		clrWrap  = 1'b0;
		regs_nxt = regs_r;

		// capture each write channel on its own handshake
		if (awFire) begin
			regs_nxt.awHeld = 1'b1;
			regs_nxt.awAddr = awaddr;
		end
		if (wFire) begin
			regs_nxt.wHeld = 1'b1;
			regs_nxt.wData = wdata;
			regs_nxt.wStrb = wstrb;
		end

		// write: act once both halves are held
		unique case (regs_r.wrState)
			WR_IDLE: begin
				if (regs_r.awHeld && regs_r.wHeld) begin
					regs_nxt.awHeld  = 1'b0;
					regs_nxt.wHeld   = 1'b0;
					regs_nxt.wrState = WR_RESP;
					regs_nxt.bResp   = RESP_OKAY;
					if (wrOff == CTRL_OFF) begin
						// only byte lane 0 carries control bits
						if (regs_r.wStrb[0]) begin
							regs_nxt.decade  = regs_r.wData[CTRL_DECADE_BIT];
							regs_nxt.gate    = regs_r.wData[CTRL_GATE_BIT];
							regs_nxt.swClear = regs_r.wData[CTRL_CLEAR_BIT];
						end
					end else if (wrOff == WRAP_OFF) begin
						// any write clears, whatever the data
						clrWrap = 1'b1;
					end else if (wrOff == STATUS_OFF) begin
						// status is read-only; write is dropped
						regs_nxt.bResp = RESP_OKAY;
					end else begin
						// unmapped offset
						regs_nxt.bResp = RESP_SLVERR;
					end
				end
			end
			WR_RESP: begin
				// hold the answer until the master takes it
				if (bready) begin
					regs_nxt.wrState = WR_IDLE;
				end
			end
		endcase

		// event counter: an event in the clearing cycle survives
		if (clrWrap) begin
			regs_nxt.wrapCount = '0;
		end
		if (carryOut) begin
			// a sized one keeps the sum at WRAP_W bits, even for WRAP_W of 1
			regs_nxt.wrapCount = (clrWrap ? '0 : regs_r.wrapCount)
				+ WRAP_W'(1);
		end

		// read: one word per address, answer a cycle later
		unique case (regs_r.rdState)
			RD_IDLE: begin
				if (arFire) begin
					regs_nxt.rdState = RD_DATA;
					regs_nxt.rResp   = RESP_OKAY;
					if (rdOff == CTRL_OFF) begin
						word[CTRL_DECADE_BIT] = regs_r.decade;
						word[CTRL_GATE_BIT]   = regs_r.gate;
						word[CTRL_CLEAR_BIT]  = regs_r.swClear;
					end else if (rdOff == STATUS_OFF) begin
						// live count with the flag beside it
						word[COUNT_W-1:0]   = countOutputs;
						word[STAT_TERM_BIT] = terminalFlag;
						word[STAT_DEC_BIT]  = regs_r.decade;
					end else if (rdOff == WRAP_OFF) begin
						word[WRAP_W-1:0] = regs_r.wrapCount;
					end else begin
						// unmapped offset reads zero with an error
						regs_nxt.rResp = RESP_SLVERR;
					end
					regs_nxt.rData = word;
				end
			end
			RD_DATA: begin
				// data stands until the master takes it
				if (rready) begin
					regs_nxt.rdState = RD_IDLE;
				end
			end
		endcase
	end

	// ==========================================================
	// state register
	// bus side is reset only by rst; the pin clear touches
	// the count alone so software settings survive it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			regs_r <= REGS_RST;
		end else begin
			regs_r <= regs_nxt;
		end
	end

endmodule // sync_four_bit_counter

// ### testbench/sync_four_bit_counter_checker.sv
/*
 Checker on the counter pins of the top module.
 Assumes pins change only after clk edges; bound below.
*/
`timescale 1ns/1ps

module sync_four_bit_counter_checker
	import counter_pkg::*;
(
	input wire logic                            clk,
	input wire logic                            rst,
	input wire logic                            masterClearN,
	input wire logic                            clockRise,
	input wire logic                            parallelLoadN,
	input wire logic                            countEnableParallel,
	input wire logic                            countEnableTrickle,
	input wire logic [counter_pkg::COUNT_W-1:0] presetInputs,
	input wire logic [counter_pkg::COUNT_W-1:0] countOutputs,
	input wire logic                            terminalFlag
);
	// =======
	// one domain, so clocking and reset are given once
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// acting edge with load released; the clear must stay off
	wire logic tickRun = masterClearN && clockRise && parallelLoadN;
	wire logic bothEn  = countEnableParallel && countEnableTrickle;

	chk_clear_zero:
	assert property (!masterClearN |-> countOutputs == COUNT_ZERO)
		else $error("count not zero under clear");
	chk_idle_hold:
	assert property (masterClearN && !clockRise ##1 masterClearN |-> $stable(countOutputs))
		else $error("count moved without tick");
	chk_preset_load:
	assert property (masterClearN && clockRise && !parallelLoadN ##1 masterClearN
		|-> countOutputs == $past(presetInputs))
		else $error("preset not loaded");
	chk_enable_hold:
	assert property (tickRun && !bothEn ##1 masterClearN |-> $stable(countOutputs))
		else $error("count moved with an enable low");
	chk_count_step:
	assert property (tickRun && bothEn && !terminalFlag && countOutputs != BIN_LAST
		##1 masterClearN |-> countOutputs == $past(countOutputs) + COUNT_STEP)
		else $error("count did not step by one");
	chk_final_wrap:
	assert property (tickRun && countEnableParallel && terminalFlag ##1 masterClearN
		|-> countOutputs == COUNT_ZERO)
		else $error("final state did not wrap");
	chk_flag_decode:
	assert property (terminalFlag |-> countOutputs == BCD_LAST || countOutputs == BIN_LAST)
		else $error("flag outside final state");
	chk_flag_trickle:
	assert property (!countEnableTrickle |-> !terminalFlag)
		else $error("flag without trickle enable");
endmodule // sync_four_bit_counter_checker

bind sync_four_bit_counter sync_four_bit_counter_checker chk_i (.clk, .rst, .masterClearN,
	.clockRise, .parallelLoadN, .countEnableParallel, .countEnableTrickle, .presetInputs,
	.countOutputs, .terminalFlag);

// ### testbench/cascade_stage.sv
/*
 Next decade stage of a cascade, enabled by the flag.
 Assumes it shares clk and the clear with the stage under test.
*/
`timescale 1ns/1ps

module cascade_stage (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       clearN,
	input  wire logic       tick,
	input  wire logic       enable,
	output logic      [3:0] count
);
	// =======
	// clear acts at once, else only rising edges
	// flag and parallel enable gate it
	always_ff @(posedge clk or posedge rst or negedge clearN) begin
		if (rst || !clearN) begin
			count <= 4'h0;
		end else if (tick && enable) begin
			count <= (count == 4'h9) ? 4'h0 : count + 4'h1;
		end
	end
endmodule // cascade_stage

// ### testbench/sync_four_bit_counter_tb.sv
/*
 Bench: bus tasks, pin sequences, a per-cycle reference count.
 Assumes 10 MHz clk; pins are held off during bus traffic.
*/
`timescale 1ns/1ps

module sync_four_bit_counter_tb;
	import counter_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, masterClearN = 1'b1, clockRise = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        parallelLoadN = 1'b1, countEnableParallel = 1'b0, countEnableTrickle = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [3:0]  wstrb = 4'h0, presetInputs = 4'h0, countOutputs, nextCount, expC, expHi;
	logic        awready, wready, bvalid, arready, rvalid, terminalFlag, fl;
	logic        decMode = 1'b1;
	logic [1:0]  bresp, rresp, rsp;
	int          failures = 0, comparisons = 0, cyc = 0, expWrap = 0;

	sync_four_bit_counter DUT (.*);
	// far side: a second stage fed by the flag
	cascade_stage nextStage (.clk, .rst, .clearN(masterClearN), .tick(clockRise),
		.enable(terminalFlag && countEnableParallel), .count(nextCount));

	initial begin
		forever #50 clk = ~clk;
	end

	// =======
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task stop_test;
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ready is looked at mid-cycle, so each channel drops at its own edge
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic aT, wT, v;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		v = 1'b0;
		while (!v) begin
			@(negedge clk);
			aT = awready && awvalid;
			wT = wready && wvalid;
			v = bvalid;
			rsp = bresp;
			@(posedge clk);
			if (aT) awvalid <= 1'b0;
			if (wT) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chk(rsp, e);
	endtask

	task rdr(input logic [7:0] a, input logic [1:0] e);
		logic aT, v;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		v = 1'b0;
		while (!v) begin
			@(negedge clk);
			aT = arready && arvalid;
			v = rvalid;
			rd = rdata;
			rsp = rresp;
			@(posedge clk);
			if (aT) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		chk(rsp, e);
	endtask

	// pins move just after the rising edge, while clk is high
	// m = {clear_n, tick, load_n, enable parallel, enable trickle}
	task pins(input logic [4:0] m, input logic [3:0] v, input int n);
		@(posedge clk);
		masterClearN <= m[4];
		clockRise <= m[3];
		parallelLoadN <= m[2];
		countEnableParallel <= m[1];
		countEnableTrickle <= m[0];
		presetInputs <= v;
		repeat (n) @(negedge clk);
	endtask

	// reference: compare mid-cycle, then predict the next acting edge
	always @(negedge clk) begin
		if (rst || !masterClearN) begin
			expC = COUNT_ZERO;
			expHi = COUNT_ZERO;
		end
		fl = countEnableTrickle && expC == (decMode ? BCD_LAST : BIN_LAST);
		if (!rst) begin
			chk(countOutputs, expC);
			chk(terminalFlag, fl);
			chk(nextCount, expHi);
		end
		if (!rst && masterClearN && clockRise) begin
			if (countEnableParallel && fl) expHi = (expHi == BCD_LAST) ? 4'h0 : expHi + 4'h1;
			if (!parallelLoadN) begin
				expC = presetInputs;
			end else if (countEnableParallel && countEnableTrickle) begin
				expWrap += fl;
				expC = (fl || (decMode && expC == BIN_LAST)) ? COUNT_ZERO : expC + COUNT_STEP;
			end
		end
	end

	// hang guard: the sequence needs well under 1000 cycles
	initial begin
		forever begin
			@(posedge clk);
			cyc++;
			if (cyc == 3000) begin
				failures++;
				stop_test;
			end
		end
	end

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdr(CTRL_OFF, RESP_OKAY);
		chk(rd, 32'h3);
		rdr(STATUS_OFF, RESP_OKAY);
		chk(rd, 32'h20);
		rdr(8'h0C, RESP_SLVERR);
		chk(rd, 32'h0);
		wr(STATUS_OFF, 32'hF, RESP_OKAY);
		pins(5'h1F, 4'h0, 12); // through nine and back
		pins(5'h1E, 4'h0, 3); // trickle low holds
		pins(5'h1D, 4'h0, 3); // parallel low holds
		pins(5'h1B, 4'h9, 1); // preset wins over enables
		pins(5'h17, 4'h0, 3); // no tick, flag stands at nine
		pins(5'h1B, 4'hC, 1); // illegal decade state
		pins(5'h1F, 4'h0, 6); // recovery
		pins(5'h0F, 4'h0, 2); // clear while counting
		pins(5'h16, 4'h0, 1);
		rdr(STATUS_OFF, RESP_OKAY);
		chk(rd, {26'h0, 2'b10, expC});
		rdr(WRAP_OFF, RESP_OKAY);
		chk(rd, expWrap);
		wr(WRAP_OFF, 32'h0, RESP_OKAY);
		expWrap = 0;
		rdr(WRAP_OFF, RESP_OKAY);
		chk(rd, 32'h0);
		wr(CTRL_OFF, 32'h2, RESP_OKAY);
		decMode = 1'b0;
		pins(5'h1B, 4'hD, 1);
		pins(5'h1F, 4'h0, 5); // binary through fifteen
		pins(5'h16, 4'h0, 1);
		rdr(STATUS_OFF, RESP_OKAY);
		chk(rd, {28'h0, expC});
		rdr(WRAP_OFF, RESP_OKAY);
		chk(rd, expWrap);
		stop_test;
	end
endmodule // sync_four_bit_counter_tb
